// File: pkg/exc_status_pkg.sv
// Purpose: Shared constants, codes and carriers for the exception vector status block
// Assumes: One core clock, synchronous active-high reset, APB register access
// Notes:   Priorities are 3 bits, lower value wins; zero base mask means no masking
package exc_status_pkg;

  localparam int          NUM_IRQ           = 30;
  localparam int          NUM_CODES         = 46;
  localparam int          PRIO_W            = 3;
  localparam int          CODE_W            = 6;
  localparam int          EFF_W             = 4;

  localparam logic [11:0] ADDR_INT_CTRL     = 12'h000;
  localparam logic [11:0] ADDR_LOOKUP_SEL   = 12'h004;
  localparam logic [11:0] ADDR_LOOKUP_RES   = 12'h008;
  localparam logic [11:0] ADDR_MASK_VIEW    = 12'h00c;

  localparam int          PEND_LSB          = 12;
  localparam int          PEND_MSB          = 17;
  localparam int          RETURN_TO_BASE_FLAG_BIT       = 11;
  localparam int          ACT_LSB           = 0;
  localparam int          ACT_MSB           = 5;
  localparam int          LK_REPORTED_BIT   = 0;
  localparam int          LK_SYSTEM_BIT     = 1;
  localparam int          LK_PERIPH_BIT     = 2;
  localparam int          LK_DEBUG_BIT      = 3;
  localparam int          LK_IDX_LSB        = 4;
  localparam int          LK_IDX_MSB        = 8;
  localparam int          MV_BASE_LSB       = 0;
  localparam int          MV_BASE_MSB       = 2;
  localparam int          MV_FAULT_BIT      = 4;
  localparam int          MV_GENERAL_BIT    = 5;
  localparam int          MV_PRIO_LSB       = 8;
  localparam int          MV_PRIO_MSB       = 11;

  localparam logic [5:0]  CODE_NONE         = 6'h00;
  localparam logic [5:0]  CODE_NMI          = 6'h02;
  localparam logic [5:0]  CODE_HARD         = 6'h03;
  localparam logic [5:0]  CODE_MEM          = 6'h04;
  localparam logic [5:0]  CODE_USAGE        = 6'h06;
  localparam logic [5:0]  CODE_SVC          = 6'h0b;
  localparam logic [5:0]  CODE_DEBUG        = 6'h0c;
  localparam logic [5:0]  CODE_PENDABLE_SERVICE_CALL       = 6'h0e;
  localparam logic [5:0]  CODE_SYSTEM_TICK_EXCEPTION      = 6'h0f;
  localparam logic [5:0]  CODE_IRQ_BASE     = 6'h10;
  localparam logic [5:0]  CODE_IRQ_LAST     = 6'h2d;

  localparam logic [3:0]  EFF_NMI           = 4'h0;
  localparam logic [3:0]  EFF_HARD          = 4'h1;
  localparam logic [3:0]  EFF_OFFSET        = 4'h2;
  localparam logic [3:0]  EFF_IDLE          = 4'hf;
  localparam logic [5:0]  RESET_CODE        = 6'h00;

  typedef enum logic [2:0] {
    CLASS_RESERVED, CLASS_DEBUG, CLASS_FIXED, CLASS_FAULT, CLASS_SYSTEM, CLASS_PERIPH
  } exc_class_type;

  typedef struct packed {
    logic [NUM_IRQ-1:0]             irqPending;
    logic [NUM_IRQ-1:0]             irqEnable;
    logic [NUM_IRQ-1:0][PRIO_W-1:0] irqPriority;
    logic [15:0]                    sysPending;
    logic [15:0]                    sysEnable;
    logic [15:0][PRIO_W-1:0]        sysPriority;
    logic [NUM_CODES-1:0]           activeSet;
    logic [PRIO_W-1:0]              basePriorityMask;
    logic                           faultDisableMask;
    logic                           generalPriorityMask;
    logic [CODE_W-1:0]              handlerNumber;
  } core_state_type;

  typedef struct packed {
    logic [CODE_W-1:0] pendingVector;
    logic              returnToBase;
    logic [CODE_W-1:0] activeVector;
  } vector_status_type;

  function automatic exc_class_type excClass(input logic [5:0] code);
    exc_class_type c;
    c = CLASS_RESERVED;
    if (code == CODE_NMI || code == CODE_HARD) begin
      c = CLASS_FIXED;
    end else if (code >= CODE_MEM && code <= CODE_USAGE) begin
      c = CLASS_FAULT;
    end else if (code == CODE_SVC || code == CODE_PENDABLE_SERVICE_CALL || code == CODE_SYSTEM_TICK_EXCEPTION) begin
      c = CLASS_SYSTEM;
    end else if (code == CODE_DEBUG) begin
      c = CLASS_DEBUG;
    end else if (code >= CODE_IRQ_BASE && code <= CODE_IRQ_LAST) begin
      c = CLASS_PERIPH;
    end
    return c;
  endfunction : excClass

endpackage : exc_status_pkg

// File: rtl/exc_active_tracker.sv
// Purpose: Decides whether preempted active exceptions remain
// Assumes: activeSet marks every active exception by number
// Notes:   NMI and faults are left out of the count
`timescale 1ns/1ps
module exc_active_tracker
  import exc_status_pkg::*;
(
  input  wire logic [NUM_CODES-1:0] activeSet,
  input  wire logic [CODE_W-1:0]    handlerNumber,
  output logic                      returnToBase
);

  logic [NUM_CODES-1:0] counted;

  genvar g;
  generate
    for (g = 0; g < NUM_CODES; g++) begin : g_count
      exc_class_type cls;
      assign cls        = excClass(CODE_W'(g));
      assign counted[g] = activeSet[g] & (cls == CLASS_SYSTEM || cls == CLASS_PERIPH);
    end
  endgenerate

  always_comb begin
    logic [CODE_W-1:0] n;
    n = '0;
    for (int i = 0; i < NUM_CODES; i++) begin
      n = n + CODE_W'(counted[i]);
    end
    // Thread mode has nothing active, so the flag reads as the idle value
    returnToBase = (handlerNumber == CODE_NONE) || (n <= CODE_W'(1));
  end

endmodule : exc_active_tracker

// File: rtl/exc_priority_resolver.sv
// Purpose: Picks the highest-priority pending enabled exception
// Assumes: Inputs from core logic on the same clock
// Notes:   Purely combinational; ties go to the lower exception number
`timescale 1ns/1ps
module exc_priority_resolver
  import exc_status_pkg::*;
(
  input  wire core_state_type   coreState,
  output logic [CODE_W-1:0]     winCode,
  output logic [EFF_W-1:0]      winPriority
);

  always_comb begin
    logic [EFF_W-1:0] eff;
    logic             req;
    exc_class_type    cls;
    eff         = EFF_IDLE;
    req         = 1'b0;
    cls         = CLASS_RESERVED;
    winCode     = CODE_NONE;
    winPriority = EFF_IDLE;
    for (int i = 0; i < NUM_CODES; i++) begin
      eff = EFF_IDLE;
      req = 1'b0;
      cls = excClass(CODE_W'(i));
      unique case (cls)
        CLASS_FIXED: begin
          req = coreState.sysPending[i];
          eff = (CODE_W'(i) == CODE_NMI) ? EFF_NMI : EFF_HARD;
        end
        CLASS_FAULT, CLASS_SYSTEM: begin
          req = coreState.sysPending[i] & coreState.sysEnable[i];
          eff = {1'b0, coreState.sysPriority[i]} + EFF_OFFSET;
        end
        CLASS_PERIPH: begin
          req = coreState.irqPending[i-16] & coreState.irqEnable[i-16];
          eff = {1'b0, coreState.irqPriority[i-16]} + EFF_OFFSET;
        end
        CLASS_RESERVED, CLASS_DEBUG: begin
          req = 1'b0;
        end
      endcase
      // Fault mask leaves only NMI; the general mask is deliberately not consulted
      if (coreState.faultDisableMask && eff != EFF_NMI) begin
        req = 1'b0;
      end
      if (coreState.basePriorityMask != '0 && eff >= ({1'b0, coreState.basePriorityMask} + EFF_OFFSET)) begin
        req = 1'b0;
      end
      if (req && eff < winPriority) begin
        winPriority = eff;
        winCode     = CODE_W'(i);
      end
    end
  end

endmodule : exc_priority_resolver

// File: rtl/exception_vector_status.sv
// Purpose: APB view of the exception vector status fields of the core
// Assumes: coreState comes from core logic on clk_sys, so no synchroniser is used
// Notes:   Status is re-sampled every cycle; reads are zero-wait
//
// What this block does
// - Bits 17:12 give the highest-priority pending enabled exception number.
// - Pending field honours base priority and fault masks, ignores general mask.
// - Pending field reads zero when nothing is pending.
// - System exceptions use codes 2,3,4,5,6,11,14,15.
// - Codes 1, 7-10, 13, 46-63 never reported; 12 is debug-reserved.
// - Peripheral interrupts 0-29 map to codes 16-45 in order.
// - Bit 11 reads 0 if preempted exceptions remain, else 1.
// - Return flag excludes NMI and faults, meaningful only inside a handler.
// - Bits 5:0 hold the active exception number, same encoding.
// - Active field zero means Thread mode.
// - Active field equals the handler number of program status one clock earlier.
// - Bits 10:6 read zero; software preserves them on read-modify-write.
// - The three fields are read-only and reset to zero.
//
// Decided for this implementation: the register addresses and the APB slave port.
`timescale 1ns/1ps
module exception_vector_status
  import exc_status_pkg::*;
(
  input  wire logic              clk_sys,
  input  wire logic              srst,
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [11:0]       paddr,
  input  wire logic [31:0]       pwdata,
  input  wire logic [3:0]        pstrb,
  output logic [31:0]            prdata,
  output logic                   pready,
  output logic                   pslverr,
  input  wire core_state_type    coreState,
  output vector_status_type      vectorStatus
);

  logic [CODE_W-1:0]  resolvedCode;
  logic [EFF_W-1:0]   resolvedPriority;
  logic               trackedReturn;

  logic [CODE_W-1:0]  pendingVectorField;
  logic               returnToBaseFlag;
  logic [CODE_W-1:0]  activeVectorField;
  logic [EFF_W-1:0]   pendingPriority;

  logic [CODE_W-1:0]  lookupSelect;
  logic [31:0]        lookupResult;
  logic [31:0]        maskView;
  logic [31:0]        controlStateWord;

  logic               accessPhase;
  logic               writeAccess;
  logic               readAccess;
  logic               addrMapped;
  logic               addrWritable;
  logic [31:0]        next_prdata;

  exc_priority_resolver u_resolver (
    .coreState   (coreState),
    .winCode     (resolvedCode),
    .winPriority (resolvedPriority)
  );

  exc_active_tracker u_tracker (
    .activeSet     (coreState.activeSet),
    .handlerNumber (coreState.handlerNumber),
    .returnToBase  (trackedReturn)
  );

  // Status capture: one flop stage so the read mux sees a stable word

  always_ff @(posedge clk_sys) begin
    if (srst) begin
      pendingVectorField <= RESET_CODE;
    end else begin
      // Resolver returns zero when no candidate survives masking
      pendingVectorField <= resolvedCode;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (srst) begin
      pendingPriority <= EFF_IDLE;
    end else if (resolvedCode == CODE_NONE) begin
      pendingPriority <= EFF_IDLE;
    end else begin
      pendingPriority <= resolvedPriority;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (srst) begin
      // Reset value zero, although the flag's idle meaning is one
      returnToBaseFlag <= 1'b0;
    end else begin
      returnToBaseFlag <= trackedReturn;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (srst) begin
      activeVectorField <= RESET_CODE;
    end else begin
      // Copied straight from program status; zero there is Thread mode
      activeVectorField <= coreState.handlerNumber;
    end
  end

  assign vectorStatus.pendingVector = pendingVectorField;
  assign vectorStatus.returnToBase  = returnToBaseFlag;
  assign vectorStatus.activeVector  = activeVectorField;

  // Register word assembly

  always_comb begin
    controlStateWord = '0;
    controlStateWord[PEND_MSB:PEND_LSB] = pendingVectorField;
    controlStateWord[RETURN_TO_BASE_FLAG_BIT]       = returnToBaseFlag;
    controlStateWord[ACT_MSB:ACT_LSB]   = activeVectorField;
  end

  always_comb begin
    exc_class_type cls;
    logic [CODE_W-1:0] idx;
    cls = excClass(lookupSelect);
    idx = lookupSelect - CODE_IRQ_BASE;
    lookupResult = '0;
    // Reserved codes flag nothing, so software can see they are never reported
    lookupResult[LK_REPORTED_BIT] = (cls != CLASS_RESERVED) && (cls != CLASS_DEBUG);
    lookupResult[LK_SYSTEM_BIT]   = (cls == CLASS_FIXED) || (cls == CLASS_FAULT) || (cls == CLASS_SYSTEM);
    lookupResult[LK_DEBUG_BIT]    = (cls == CLASS_DEBUG);
    lookupResult[LK_PERIPH_BIT]   = (cls == CLASS_PERIPH);
    if (cls == CLASS_PERIPH) begin
      lookupResult[LK_IDX_MSB:LK_IDX_LSB] = idx[4:0];
    end
  end

  always_comb begin
    maskView = '0;
    maskView[MV_BASE_MSB:MV_BASE_LSB] = coreState.basePriorityMask;
    maskView[MV_FAULT_BIT]            = coreState.faultDisableMask;
    maskView[MV_GENERAL_BIT]          = coreState.generalPriorityMask;
    maskView[MV_PRIO_MSB:MV_PRIO_LSB] = pendingPriority;
  end

  // APB slave: zero wait states, error only for unmapped addresses

  assign accessPhase = psel & penable;
  assign writeAccess = accessPhase & pwrite;
  assign readAccess  = accessPhase & ~pwrite;
  assign pready      = 1'b1;

  always_comb begin
    addrMapped   = 1'b0;
    addrWritable = 1'b0;
    unique case (paddr)
      ADDR_INT_CTRL: begin
        addrMapped = 1'b1;
      end
      ADDR_LOOKUP_SEL: begin
        addrMapped   = 1'b1;
        addrWritable = 1'b1;
      end
      ADDR_LOOKUP_RES: begin
        addrMapped = 1'b1;
      end
      ADDR_MASK_VIEW: begin
        addrMapped = 1'b1;
      end
      default: begin
        addrMapped = 1'b0;
      end
    endcase
  end

  // Writes to read-only words complete without error and change nothing
  assign pslverr = accessPhase & ~addrMapped;

  always_ff @(posedge clk_sys) begin
    if (srst) begin
      lookupSelect <= RESET_CODE;
    end else if (writeAccess && addrWritable && pstrb[0]) begin
      lookupSelect <= pwdata[CODE_W-1:0];
    end
  end

  always_comb begin
    next_prdata = '0;
    unique case (paddr)
      ADDR_INT_CTRL: begin
        next_prdata = controlStateWord;
      end
      ADDR_LOOKUP_SEL: begin
        next_prdata = {26'h0000000, lookupSelect};
      end
      ADDR_LOOKUP_RES: begin
        next_prdata = lookupResult;
      end
      ADDR_MASK_VIEW: begin
        next_prdata = maskView;
      end
      default: begin
        next_prdata = '0;
      end
    endcase
  end

  // Read data is driven during the access phase so the master samples it at pready
  always_comb begin
    if (readAccess) begin
      prdata = next_prdata;
    end else begin
      prdata = '0;
    end
  end

endmodule : exception_vector_status

// File: verification/core_model.sv
// Purpose: Behavioural core exception state feeding the status block
// Assumes: Tasks are called just after a rising edge
// Notes:   Handler number tracks the executing exception only
`timescale 1ns/1ps
module core_model
  import exc_status_pkg::*;
(
  input  wire logic     clk_sys,
  output core_state_type coreState
);
  initial coreState = '0;
  task automatic clear();
    coreState <= '0;
  endtask : clear
  // Peripheral codes map back to index code-16
  task automatic pend(input logic [5:0] code, input logic [2:0] prio);
    if (code >= CODE_IRQ_BASE) begin
      coreState.irqPending[code-CODE_IRQ_BASE]  <= 1'b1;
      coreState.irqEnable[code-CODE_IRQ_BASE]   <= 1'b1;
      coreState.irqPriority[code-CODE_IRQ_BASE] <= prio;
    end else begin
      coreState.sysPending[code]  <= 1'b1;
      coreState.sysEnable[code]   <= 1'b1;
      coreState.sysPriority[code] <= prio;
    end
  endtask : pend
  task automatic activate(input logic [5:0] code, input logic run);
    coreState.activeSet[code] <= 1'b1;
    if (run) coreState.handlerNumber <= code;
  endtask : activate
  task automatic masks(input logic [2:0] base, input logic fault, input logic gen);
    coreState.basePriorityMask    <= base;
    coreState.faultDisableMask    <= fault;
    coreState.generalPriorityMask <= gen;
  endtask : masks
endmodule : core_model

// File: verification/exc_status_properties.sv
// Purpose: Port assertions for the exception vector status block
// Assumes: Status fields lag core state by one clock
// Notes:   Bound to exception_vector_status below
`timescale 1ns/1ps
module exc_status_properties
  import exc_status_pkg::*;
(
  input wire logic              clk_sys,
  input wire logic              srst,
  input wire logic              psel,
  input wire logic              penable,
  input wire logic              pwrite,
  input wire logic [11:0]       paddr,
  input wire logic [31:0]       pwdata,
  input wire logic [3:0]        pstrb,
  input wire logic [31:0]       prdata,
  input wire logic              pready,
  input wire logic              pslverr,
  input wire core_state_type    coreState,
  input wire vector_status_type vectorStatus
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (srst);
  // First edge after reset still shows reset values, so it is skipped
  sequence s_run; !$past(srst); endsequence
  sequence s_rd0; psel && penable && !pwrite && paddr == ADDR_INT_CTRL; endsequence
  property p_act_follow; s_run |-> vectorStatus.activeVector == $past(coreState.handlerNumber); endproperty
  property p_reset_zero; disable iff (1'b0) srst |=> vectorStatus == '0; endproperty
  property p_word_map; s_rd0 |-> prdata[17:12] == vectorStatus.pendingVector
    && prdata[11] == vectorStatus.returnToBase && prdata[5:0] == vectorStatus.activeVector; endproperty
  property p_rsvd_zero; s_rd0 |-> prdata[31:18] == 14'h0000 && prdata[10:6] == 5'h00; endproperty
  property p_no_rsvd; s_run |-> !(vectorStatus.pendingVector inside {6'h01, [6'h07:6'h0a], 6'h0d, [6'h2e:6'h3f]});
  endproperty
  property p_none; s_run ##0 $past(coreState.sysPending == 16'h0000 && coreState.irqPending == '0)
    |-> vectorStatus.pendingVector == 6'h00; endproperty
  property p_fault_mask; s_run ##0 $past(coreState.faultDisableMask && !coreState.sysPending[2])
    |-> vectorStatus.pendingVector == 6'h00; endproperty
  property p_base; s_run ##0 $past(coreState.handlerNumber) == 6'h00 |-> vectorStatus.returnToBase; endproperty
  a_act_follow: assert property (p_act_follow) else $error("active field not following handler");
  a_reset_zero: assert property (p_reset_zero) else $error("status not zero after reset");
  a_word_map: assert property (p_word_map) else $error("status word fields misplaced");
  a_rsvd_zero: assert property (p_rsvd_zero) else $error("reserved bits not zero");
  a_no_rsvd: assert property (p_no_rsvd) else $error("reserved code reported");
  a_none: assert property (p_none) else $error("pending field nonzero with nothing pending");
  a_fault_mask: assert property (p_fault_mask) else $error("fault mask not applied");
  a_base: assert property (p_base) else $error("return flag low in thread mode");
endmodule : exc_status_properties

bind exception_vector_status exc_status_properties exc_status_properties_inst (.clk_sys(clk_sys), .srst(srst),
  .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
  .prdata(prdata), .pready(pready), .pslverr(pslverr), .coreState(coreState), .vectorStatus(vectorStatus));

// File: verification/testbench.sv
// Purpose: Self-checking bench for the exception vector status block
// Assumes: Zero-wait APB slave, status one clock behind core state
// Notes:   Core state comes from core_model tasks
`timescale 1ns/1ps
module testbench
  import exc_status_pkg::*;
();
  logic              clk_sys, srst, psel, penable, pwrite, pready, pslverr;
  logic [11:0]       paddr;
  logic [31:0]       pwdata, prdata, rd;
  logic [3:0]        pstrb;
  logic              err;
  core_state_type    coreState;
  vector_status_type vectorStatus;
  int                fails, n_checks, cycles;

  exception_vector_status exception_vector_status_inst (.clk_sys(clk_sys), .srst(srst), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .coreState(coreState), .vectorStatus(vectorStatus));
  core_model core_model_inst (.clk_sys(clk_sys), .coreState(coreState));

  initial begin
    clk_sys = 0;
    forever #10 clk_sys = ~clk_sys;
  end

  task automatic complete_run();
    $display("checks %0d mismatches %0d", n_checks, fails);
    if (fails == 0 && n_checks > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : complete_run

  task automatic check32(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      fails++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : check32

  // Waits for pready at an edge; read data is taken at that edge only
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] wd);
    int n;
    @(posedge clk_sys);
    psel <= 1; penable <= 0; pwrite <= wr; paddr <= a; pwdata <= wd;
    @(posedge clk_sys);
    penable <= 1;
    for (n = 0; n < 20; n++) begin
      @(posedge clk_sys);
      if (pready === 1'b1) break;
    end
    if (n == 20) begin
      fails++;
      $display("wrong value at %0t: no pready on access", $time);
    end
    rd = prdata; err = pslverr;
    psel <= 0; penable <= 0;
  endtask : apb

  task automatic read_check(input logic [5:0] pend, input logic rb, input logic [5:0] act);
    apb(1'b0, ADDR_INT_CTRL, 32'h0);
    check32(rd, {14'h0000, pend, rb, 5'h00, act});
  endtask : read_check

  task automatic test_codes();
    logic [5:0] sysCodes [8] = '{6'h02, 6'h03, 6'h04, 6'h05, 6'h06, 6'h0b, 6'h0e, 6'h0f};
    for (int i = 0; i < 8; i++) begin
      core_model_inst.clear();
      core_model_inst.pend(sysCodes[i], 3'h4);
      read_check(sysCodes[i], 1'b1, 6'h00);
    end
    for (int i = 0; i < NUM_IRQ; i++) begin
      core_model_inst.clear();
      core_model_inst.pend(6'(16 + i), 3'h2);
      read_check(6'(16 + i), 1'b1, 6'h00);
    end
    // Reserved and debug codes pending must never reach the field
    core_model_inst.clear();
    core_model_inst.pend(6'h01, 3'h0);
    core_model_inst.pend(6'h07, 3'h0);
    core_model_inst.pend(6'h0c, 3'h0);
    core_model_inst.pend(6'h0d, 3'h0);
    read_check(6'h00, 1'b1, 6'h00);
    $display("test_codes done");
  endtask : test_codes

  task automatic test_priority();
    core_model_inst.clear();
    core_model_inst.pend(6'h15, 3'h3);
    core_model_inst.pend(6'h12, 3'h1);
    read_check(6'h12, 1'b1, 6'h00);
    core_model_inst.masks(3'h2, 1'b0, 1'b1);
    read_check(6'h12, 1'b1, 6'h00);
    core_model_inst.masks(3'h1, 1'b0, 1'b0);
    read_check(6'h00, 1'b1, 6'h00);
    core_model_inst.clear();
    core_model_inst.pend(6'h03, 3'h0);
    core_model_inst.masks(3'h0, 1'b1, 1'b0);
    read_check(6'h00, 1'b1, 6'h00);
    core_model_inst.pend(6'h02, 3'h0);
    read_check(6'h02, 1'b1, 6'h00);
    core_model_inst.clear();
    core_model_inst.pend(6'h19, 3'h2);
    core_model_inst.pend(6'h17, 3'h2);
    read_check(6'h17, 1'b1, 6'h00);
    $display("test_priority done");
  endtask : test_priority

  task automatic test_active();
    core_model_inst.clear();
    core_model_inst.activate(6'h14, 1'b1);
    read_check(6'h00, 1'b1, 6'h14);
    check32(32'(rd[5:0]) - 32'd16, 32'd4);
    core_model_inst.activate(CODE_SVC, 1'b0);
    read_check(6'h00, 1'b0, 6'h14);
    core_model_inst.clear();
    core_model_inst.activate(CODE_HARD, 1'b0);
    core_model_inst.activate(CODE_MEM, 1'b0);
    core_model_inst.activate(6'h14, 1'b1);
    read_check(6'h00, 1'b1, 6'h14);
    core_model_inst.clear();
    read_check(6'h00, 1'b1, 6'h00);
    $display("test_active done");
  endtask : test_active

  task automatic test_bus();
    core_model_inst.pend(6'h2d, 3'h1);
    core_model_inst.activate(CODE_PENDABLE_SERVICE_CALL, 1'b1);
    read_check(6'h2d, 1'b1, CODE_PENDABLE_SERVICE_CALL);
    apb(1'b1, ADDR_INT_CTRL, rd ^ 32'h0003_f83f);
    read_check(6'h2d, 1'b1, CODE_PENDABLE_SERVICE_CALL);
    apb(1'b0, 12'h010, 32'h0);
    check32({rd[30:0], err}, 32'h1);
    $display("test_bus done");
  endtask : test_bus

  task automatic test_lookup();
    core_model_inst.clear();
    core_model_inst.pend(6'h2d, 3'h1);
    core_model_inst.masks(3'h5, 1'b0, 1'b1);
    apb(1'b0, ADDR_MASK_VIEW, 32'h0);
    check32(rd, 32'h0000_0325);
    check32({31'h0, err}, 32'h0);
    apb(1'b1, ADDR_LOOKUP_SEL, 32'h0000_0014);
    apb(1'b0, ADDR_LOOKUP_SEL, 32'h0);
    check32(rd, 32'h0000_0014);
    apb(1'b0, ADDR_LOOKUP_RES, 32'h0);
    check32(rd, 32'h0000_0045);
    apb(1'b1, ADDR_LOOKUP_SEL, 32'h0000_000b);
    apb(1'b0, ADDR_LOOKUP_RES, 32'h0);
    check32(rd, 32'h0000_0003);
    apb(1'b1, ADDR_LOOKUP_SEL, 32'h0000_000c);
    apb(1'b0, ADDR_LOOKUP_RES, 32'h0);
    check32(rd, 32'h0000_0008);
    apb(1'b1, ADDR_LOOKUP_SEL, 32'h0000_002e);
    // Lane 0 off: the select must keep its old code
    pstrb <= 4'he;
    apb(1'b1, ADDR_LOOKUP_SEL, 32'h0000_0014);
    pstrb <= 4'hf;
    apb(1'b0, ADDR_LOOKUP_RES, 32'h0);
    check32(rd, 32'h0000_0000);
    // Mid-run reset must clear the status word and the lookup select
    srst <= 1;
    repeat (2) @(posedge clk_sys);
    check32(32'(vectorStatus), 32'h0);
    srst <= 0;
    apb(1'b0, ADDR_LOOKUP_SEL, 32'h0);
    check32(rd, 32'h0);
    read_check(6'h2d, 1'b1, 6'h00);
    $display("test_lookup done");
  endtask : test_lookup

  always @(posedge clk_sys) begin
    cycles++;
    if (cycles == 3000) begin
      fails++;
      complete_run();
    end
  end

  initial begin
    srst = 1; psel = 0; penable = 0; pwrite = 0; paddr = 12'h000;
    pwdata = 32'h0; pstrb = 4'hf; fails = 0; n_checks = 0; cycles = 0;
    repeat (6) @(posedge clk_sys);
    check32(32'(vectorStatus), 32'h0);
    srst <= 0;
    read_check(6'h00, 1'b1, 6'h00);
    $display("test_reset done");
    test_codes();
    test_priority();
    test_active();
    test_bus();
    test_lookup();
    complete_run();
  end
endmodule : testbench
